/* rdsr_pkg.sv */
// constants and types shared by the reader status register bank
// assumes one 125 MHz core clock and an 8-bit internal register port
`default_nettype none
package rdsr_pkg;
  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 6;      // register address width
  localparam int          DATA_W         = 8;      // register data width
  localparam logic [5:0]  PRIMARY_ADDR   = 6'h07;  // primary_status
  localparam logic [5:0]  SECONDARY_ADDR = 6'h08;  // secondary_status
  localparam logic [7:0]  PRIMARY_RST    = 8'h21;  // primary_status reset
  localparam logic [7:0]  SECONDARY_RST  = 8'h00;  // secondary_status reset
  localparam logic [7:0]  RDATA_RST      = 8'h00;  // read latch after reset
  // ----------------------------------------------------------------
  // primary_status field positions
  // ----------------------------------------------------------------
  localparam int          P_CRC_ZERO     = 6;
  localparam int          P_CRC_DONE     = 5;
  localparam int          P_IRQ          = 4;
  localparam int          P_TIMER_RUN    = 3;
  localparam int          P_HIGH_WM      = 1;
  localparam int          P_LOW_WM       = 0;
  // ----------------------------------------------------------------
  // secondary_status field positions
  // ----------------------------------------------------------------
  localparam int          S_THERMAL_CLR  = 7;
  localparam int          S_FAST_FORCE   = 6;
  localparam int          S_CRYPTO_ON    = 3;
  // ----------------------------------------------------------------
  // buffer and interrupt sizes
  // ----------------------------------------------------------------
  localparam logic [6:0]  BUF_DEPTH      = 7'h40;  // 64-byte buffer
  localparam int          CNT_W          = 7;      // byte count 0..64
  localparam int          WM_W           = 6;      // watermark threshold
  localparam int          MAIN_IRQ_W     = 7;      // main interrupt sources
  localparam int          MISC_IRQ_W     = 2;      // misc interrupt sources
  localparam int          TXW_W          = 8;      // transmit wait count
  localparam logic [7:0]  TXW_ZERO       = 8'h00;
  localparam logic [7:0]  TXW_ONE        = 8'h01;
  localparam logic [1:0]  GATE_OFF       = 2'h0;   // timer not gated
  // ----------------------------------------------------------------
  // modem state encoding
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODEM_IDLE    = 3'b000,
    MODEM_WAIT_SS = 3'b001,
    MODEM_TX_WAIT = 3'b010,
    MODEM_SENDING = 3'b011
  } rdsr_modem_t;
endpackage
`default_nettype wire

/* rdsr_watermark.sv */
// buffer fill watermark comparator with registered alerts
// assumes the byte count never exceeds the buffer depth
`timescale 1ns/10ps
`default_nettype none
module rdsr_watermark (
  input  wire logic       i_mclk,           // core clock
  input  wire logic       i_rst_n,          // async reset, active low
  input  wire logic [6:0] i_buffer_byte_count,   // bytes held
  input  wire logic [5:0] i_watermark_threshold, // alert threshold
  output logic            o_high_watermark_alert,
  output logic            o_low_watermark_alert
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic high;  // free space at or below threshold
    logic low;   // fill at or below threshold
  } rdsr_wm_t;
  rdsr_wm_t   st_r;
  rdsr_wm_t   st_nxt;
  logic [6:0] free_bytes;  // space left in the buffer
  logic [6:0] thr_ext;     // threshold widened to count width

  // free space and both comparisons
  always_comb begin
    free_bytes  = rdsr_pkg::BUF_DEPTH - i_buffer_byte_count;
    thr_ext     = {1'b0, i_watermark_threshold};
    st_nxt.high = (free_bytes <= thr_ext);
    st_nxt.low  = (i_buffer_byte_count <= thr_ext);
  end

  // empty buffer after reset, so only the low alert is up
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '{high: 1'b0, low: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_high_watermark_alert = st_r.high;
  assign o_low_watermark_alert  = st_r.low;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_high_alert;
    @(posedge i_mclk) disable iff (!i_rst_n)
    ##1 o_high_watermark_alert ==
        ($past(rdsr_pkg::BUF_DEPTH - i_buffer_byte_count) <=
         {1'b0, $past(i_watermark_threshold)});
  endproperty
  a_high_alert: assert property (p_high_alert) else $error("high alert wrong");

  property p_low_alert;
    @(posedge i_mclk) disable iff (!i_rst_n)
    ##1 o_low_watermark_alert ==
        ($past(i_buffer_byte_count) <= {1'b0, $past(i_watermark_threshold)});
  endproperty
  a_low_alert: assert property (p_low_alert) else $error("low alert wrong");
endmodule
`default_nettype wire

/* rdsr_modem_fsm.sv */
// transmit/receive modem sequencer whose state is shown to software
// assumes the transmit request stays high for the whole exchange
`timescale 1ns/10ps
`default_nettype none
module rdsr_modem_fsm (
  input  wire logic       i_mclk,             // core clock
  input  wire logic       i_rst_n,            // async reset, active low
  input  wire logic       i_tx_request,       // exchange command running
  input  wire logic       i_start_send_request, // start bit from framing
  input  wire logic       i_wait_for_field_option,
  input  wire logic       i_rf_field_present, // external field seen
  input  wire logic [7:0] i_transmit_wait,    // least wait, in cycles
  input  wire logic       i_tx_done,          // last bit sent
  output logic [2:0]      o_modem_state_field,
  output logic            o_tx_go             // one-cycle start pulse
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rdsr_pkg::rdsr_modem_t st;   // sequencer state
    logic [7:0]            cnt;  // remaining wait cycles
    logic                  go;   // start pulse
  } rdsr_mdm_t;
  rdsr_mdm_t st_r;
  rdsr_mdm_t st_nxt;

  // sequencer; dropping the request aborts from any state
  always_comb begin
    st_nxt    = st_r;
    st_nxt.go = 1'b0;
    case (st_r.st)
      rdsr_pkg::MODEM_IDLE: begin
        if (i_tx_request) begin
          st_nxt.st = rdsr_pkg::MODEM_WAIT_SS;
        end
      end
      rdsr_pkg::MODEM_WAIT_SS: begin
        if (!i_tx_request) begin
          st_nxt.st = rdsr_pkg::MODEM_IDLE;
        end else if (i_start_send_request) begin
          st_nxt.st  = rdsr_pkg::MODEM_TX_WAIT;
          st_nxt.cnt = i_transmit_wait;
        end
      end
      rdsr_pkg::MODEM_TX_WAIT: begin
        if (!i_tx_request) begin
          st_nxt.st = rdsr_pkg::MODEM_IDLE;
        end else if (st_r.cnt != rdsr_pkg::TXW_ZERO) begin
          st_nxt.cnt = st_r.cnt - rdsr_pkg::TXW_ONE;
        end else if (!i_wait_for_field_option || i_rf_field_present) begin
          st_nxt.st = rdsr_pkg::MODEM_SENDING;
          st_nxt.go = 1'b1;
        end
      end
      default: begin
        if (!i_tx_request || i_tx_done) begin
          st_nxt.st = rdsr_pkg::MODEM_IDLE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '{st: rdsr_pkg::MODEM_IDLE, cnt: 8'h00, go: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_modem_state_field = st_r.st;
  assign o_tx_go             = st_r.go;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_start_seen;
    st_r.st == rdsr_pkg::MODEM_WAIT_SS && i_tx_request && i_start_send_request;
  endsequence
  sequence s_in_tx_wait;
    o_modem_state_field == 3'b010 && st_r.cnt == $past(i_transmit_wait);
  endsequence
  property p_start_to_wait;
    @(posedge i_mclk) disable iff (!i_rst_n)
    s_start_seen |=> s_in_tx_wait;
  endproperty
  a_start_to_wait: assert property (p_start_to_wait) else $error("no tx wait");

  property p_field_hold;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_r.st == rdsr_pkg::MODEM_TX_WAIT && i_wait_for_field_option &&
     !i_rf_field_present) |=> !o_tx_go;
  endproperty
  a_field_hold: assert property (p_field_hold) else $error("sent without field");
endmodule
`default_nettype wire

/* rdsr_status_bank.sv */
// reader status register bank: primary_status and secondary_status
// assumes status sources are synchronous to i_mclk and that the
// register port gives one-cycle read and write strobes
// Operation
// - checksum-zero flag in bit 6 when result zero
// - zero flag low while busy, up when done
// - checksum-done flag bit 5 after checksum command
// - bit 4 is any enabled interrupt source
// - timer-running flag bit 3 while timer counts
// - gated mode: running follows timer armed only
// - high alert when free space within threshold
// - low alert when fill within threshold
// - primary at 07h, reset 21h, read only
// - secondary at 08h, reset 00h, top bits writable
// - encryption flag set by successful authentication
// - encryption flag cleared only by host write
// - modem state shown in secondary bits 2..0
// - transmit wait holds until field present
// - modem codes idle 000, start 001, wait 010
// - force bit low: filter follows bus protocol
`timescale 1ns/10ps
`default_nettype none
module rdsr_status_bank (
  input  wire logic       i_mclk,              // 125 MHz core clock
  input  wire logic       i_rst_n,             // async reset, active low
  // register port
  input  wire logic [5:0] i_reg_addr,          // register address
  input  wire logic       i_reg_wr,            // write strobe
  input  wire logic       i_reg_rd,            // read strobe
  input  wire logic [7:0] i_reg_wdata,         // write data
  output logic      [7:0] o_reg_rdata,         // read data, next cycle
  // checksum coprocessor
  input  wire logic       i_crc_busy,          // calculation running
  input  wire logic       i_crc_finish,        // one-cycle end pulse
  input  wire logic       i_crc_result_zero,   // result equals zero
  input  wire logic       i_checksum_command,  // checksum command active
  // interrupts
  input  wire logic [6:0] i_main_irq_src,      // main sources
  input  wire logic [6:0] i_main_interrupt_enables,
  input  wire logic [1:0] i_misc_irq_src,      // misc sources
  input  wire logic [1:0] i_misc_interrupt_enables,
  // timer
  input  wire logic       i_timer_counting,    // decrements next tick
  input  wire logic       i_timer_armed,       // started, gate ignored
  input  wire logic [1:0] i_timer_gate_select, // nonzero is gated mode
  // buffer
  input  wire logic [6:0] i_buffer_byte_count,
  input  wire logic [5:0] i_watermark_threshold,
  // encryption unit
  input  wire logic       i_auth_success,      // authentication passed
  // modem
  input  wire logic       i_tx_request,
  input  wire logic       i_start_send_request,
  input  wire logic       i_wait_for_field_option,
  input  wire logic       i_rf_field_present,
  input  wire logic [7:0] i_transmit_wait,
  input  wire logic       i_tx_done,
  // host bus filter
  input  wire logic       i_hostbus_fast_mode, // protocol in use is fast
  output logic            o_hostbus_fast_filter,
  output logic            o_thermal_sensor_clear,
  output logic            o_encryption_active_flag,
  output logic            o_irq,               // combined request
  output logic            o_tx_go,             // transmitter start
  output logic      [2:0] o_modem_state_field
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       crc_zero;     // checksum_zero_flag
    logic       crc_done;     // checksum_done_flag
    logic       irq;          // combined request
    logic       timer_run;    // timer_active_flag
    logic       crypto_on;    // encryption_active_flag
    logic       thermal_clr;  // thermal_sensor_clear
    logic       fast_force;   // hostbus_fast_filter_force
    logic       fast_filter;  // filter setting in effect
    logic [7:0] rdata;        // read data latch
  } rdsr_bank_t;
  rdsr_bank_t st_r;
  rdsr_bank_t st_nxt;
  logic       high_wm;        // high_watermark_alert
  logic       low_wm;         // low_watermark_alert
  logic [2:0] modem_st;       // modem_state_field
  logic [7:0] primary_val;    // primary_status image
  logic [7:0] secondary_val;  // secondary_status image
  logic       wr_secondary;   // host write to secondary_status

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  rdsr_watermark u_wm (
    .i_mclk                 (i_mclk),
    .i_rst_n                (i_rst_n),
    .i_buffer_byte_count    (i_buffer_byte_count),
    .i_watermark_threshold  (i_watermark_threshold),
    .o_high_watermark_alert (high_wm),
    .o_low_watermark_alert  (low_wm)
  );

  rdsr_modem_fsm u_modem (
    .i_mclk                  (i_mclk),
    .i_rst_n                 (i_rst_n),
    .i_tx_request            (i_tx_request),
    .i_start_send_request    (i_start_send_request),
    .i_wait_for_field_option (i_wait_for_field_option),
    .i_rf_field_present      (i_rf_field_present),
    .i_transmit_wait         (i_transmit_wait),
    .i_tx_done               (i_tx_done),
    .o_modem_state_field     (modem_st),
    .o_tx_go                 (o_tx_go)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    wr_secondary = i_reg_wr && (i_reg_addr == rdsr_pkg::SECONDARY_ADDR);
    // register images; reserved bits stay zero
    primary_val = 8'h00;
    primary_val[rdsr_pkg::P_CRC_ZERO]  = st_r.crc_zero;
    primary_val[rdsr_pkg::P_CRC_DONE]  = st_r.crc_done;
    primary_val[rdsr_pkg::P_IRQ]       = st_r.irq;
    primary_val[rdsr_pkg::P_TIMER_RUN] = st_r.timer_run;
    primary_val[rdsr_pkg::P_HIGH_WM]   = high_wm;
    primary_val[rdsr_pkg::P_LOW_WM]    = low_wm;
    secondary_val = 8'h00;
    secondary_val[rdsr_pkg::S_THERMAL_CLR] = st_r.thermal_clr;
    secondary_val[rdsr_pkg::S_FAST_FORCE]  = st_r.fast_force;
    secondary_val[rdsr_pkg::S_CRYPTO_ON]   = st_r.crypto_on;
    secondary_val[2:0]                     = modem_st;
    // checksum result flag: forced low during the run
    if (i_crc_busy) begin
      st_nxt.crc_zero = 1'b0;
    end else if (i_crc_finish) begin
      st_nxt.crc_zero = i_crc_result_zero;
    end
    // done flag belongs to the checksum command only
    if (i_crc_finish && i_checksum_command) begin
      st_nxt.crc_done = 1'b1;
    end else if (i_crc_busy && i_checksum_command) begin
      st_nxt.crc_done = 1'b0;
    end
    // any enabled source raises the request
    st_nxt.irq = |(i_main_irq_src & i_main_interrupt_enables) ||
                 |(i_misc_irq_src & i_misc_interrupt_enables);
    // gated mode reports the enable, not the gate level
    if (i_timer_gate_select != rdsr_pkg::GATE_OFF) begin
      st_nxt.timer_run = i_timer_armed;
    end else begin
      st_nxt.timer_run = i_timer_counting;
    end
    // only the two top bits are stored; writes to primary do nothing
    if (wr_secondary) begin
      st_nxt.thermal_clr = i_reg_wdata[rdsr_pkg::S_THERMAL_CLR];
      st_nxt.fast_force  = i_reg_wdata[rdsr_pkg::S_FAST_FORCE];
    end
    // a set in the same cycle as the host clear wins
    if (i_auth_success) begin
      st_nxt.crypto_on = 1'b1;
    end else if (wr_secondary && !i_reg_wdata[rdsr_pkg::S_CRYPTO_ON]) begin
      st_nxt.crypto_on = 1'b0;
    end
    // filter follows the protocol unless forced fast
    st_nxt.fast_filter = st_r.fast_force || i_hostbus_fast_mode;
    // reads only latch data; no flag reacts to them
    if (i_reg_rd) begin
      if (i_reg_addr == rdsr_pkg::PRIMARY_ADDR) begin
        st_nxt.rdata = primary_val;
      end else if (i_reg_addr == rdsr_pkg::SECONDARY_ADDR) begin
        st_nxt.rdata = secondary_val;
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset image of primary: done flag up, zero flag down
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '{crc_zero: 1'b0, crc_done: 1'b1, irq: 1'b0,
                timer_run: 1'b0, crypto_on: 1'b0, thermal_clr: 1'b0,
                fast_force: 1'b0, fast_filter: 1'b0,
                rdata: rdsr_pkg::RDATA_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_reg_rdata              = st_r.rdata;
  assign o_hostbus_fast_filter    = st_r.fast_filter;
  assign o_thermal_sensor_clear   = st_r.thermal_clr;
  assign o_encryption_active_flag = st_r.crypto_on;
  assign o_irq                    = st_r.irq;
  assign o_modem_state_field      = modem_st;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_crc_busy_low;
    @(posedge i_mclk) disable iff (!i_rst_n)
    i_crc_busy |=> !st_r.crc_zero;
  endproperty
  a_crc_busy_low: assert property (p_crc_busy_low) else $error("zero flag up while busy");

  property p_crc_zero_set;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (!i_crc_busy && i_crc_finish) |=> st_r.crc_zero == $past(i_crc_result_zero);
  endproperty
  a_crc_zero_set: assert property (p_crc_zero_set) else $error("zero flag wrong");

  property p_crc_done;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_crc_finish && i_checksum_command) |=> st_r.crc_done;
  endproperty
  a_crc_done: assert property (p_crc_done) else $error("done flag missing");

  property p_irq;
    @(posedge i_mclk) disable iff (!i_rst_n)
    ##1 o_irq == ($past(|(i_main_irq_src & i_main_interrupt_enables)) ||
                  $past(|(i_misc_irq_src & i_misc_interrupt_enables)));
  endproperty
  a_irq: assert property (p_irq) else $error("combined request wrong");

  property p_timer_gated;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_timer_gate_select != 2'h0) |=> st_r.timer_run == $past(i_timer_armed);
  endproperty
  a_timer_gated: assert property (p_timer_gated) else $error("gated run flag wrong");

  property p_crypto_set;
    @(posedge i_mclk) disable iff (!i_rst_n)
    i_auth_success |=> o_encryption_active_flag;
  endproperty
  a_crypto_set: assert property (p_crypto_set) else $error("encryption flag not set");

  property p_crypto_hold;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (o_encryption_active_flag && !(wr_secondary && !i_reg_wdata[3]))
      |=> o_encryption_active_flag;
  endproperty
  a_crypto_hold: assert property (p_crypto_hold) else $error("encryption flag lost");

  property p_read_reserved;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_reg_rd && i_reg_addr == 6'h07) |=> (o_reg_rdata[7] == 1'b0 &&
      o_reg_rdata[2] == 1'b0 && o_reg_rdata[1:0] == $past({high_wm, low_wm}));
  endproperty
  a_read_reserved: assert property (p_read_reserved) else $error("primary read wrong");

  property p_filter;
    @(posedge i_mclk) disable iff (!i_rst_n)
    !st_r.fast_force |=> o_hostbus_fast_filter == $past(i_hostbus_fast_mode);
  endproperty
  a_filter: assert property (p_filter) else $error("filter not following bus");

  property p_timer_free;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_timer_gate_select == rdsr_pkg::GATE_OFF) |=> st_r.timer_run == $past(i_timer_counting);
  endproperty
  a_timer_free: assert property (p_timer_free) else $error("free run flag wrong");

  property p_crc_done_clear;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_crc_busy && i_checksum_command && !i_crc_finish) |=> !st_r.crc_done;
  endproperty
  a_crc_done_clear: assert property (p_crc_done_clear) else $error("done flag stuck");

  property p_crypto_clear;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (wr_secondary && !i_reg_wdata[3] && !i_auth_success) |=> !o_encryption_active_flag;
  endproperty
  a_crypto_clear: assert property (p_crypto_clear) else $error("flag not cleared");

  property p_wr_top_bits;
    @(posedge i_mclk) disable iff (!i_rst_n)
    wr_secondary |=> {o_thermal_sensor_clear, st_r.fast_force} == $past(i_reg_wdata[7:6]);
  endproperty
  a_wr_top_bits: assert property (p_wr_top_bits) else $error("top bits not written");

  sequence s_read_secondary;
    i_reg_rd && i_reg_addr == rdsr_pkg::SECONDARY_ADDR;
  endsequence
  property p_read_secondary;
    @(posedge i_mclk) disable iff (!i_rst_n)
    s_read_secondary |=> o_reg_rdata[5:4] == 2'h0 && o_reg_rdata[2:0] == $past(modem_st);
  endproperty
  a_read_secondary: assert property (p_read_secondary) else $error("secondary read wrong");

  property p_read_quiet;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_reg_rd && !i_reg_wr && !i_auth_success) |=>
      $stable(st_r.crypto_on) && $stable(st_r.thermal_clr) && $stable(st_r.fast_force);
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read changed a flag");
endmodule
`default_nettype wire

/* rdsr_host_model.sv */
// host model: drives the status bank register port with single strobes
// assumes the bench calls its tasks from one process only
`timescale 1ns/10ps
`default_nettype none
module rdsr_host_model (
  input  wire logic       i_mclk,  // core clock
  input  wire logic [7:0] i_rdata, // read data latch
  output logic      [5:0] o_addr,  // register address
  output logic            o_wr,    // write strobe
  output logic            o_rd,    // read strobe
  output logic      [7:0] o_wdata  // write data
);
  // idle bus at time zero
  initial begin
    o_addr = 6'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // host clears flags only by writing, never by reading
  task automatic wr8(input logic [5:0] a, input logic [7:0] d);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_mclk);
    #1;
    o_wr = 1'b0;
    o_wdata = ~d;
    // idle edge, so a following call never re-raises a strobe at once
    @(posedge i_mclk);
    #1;
  endtask
  // one read strobe; data taken 1 ns after the latching edge
  task automatic rd8(input logic [5:0] a, output logic [7:0] d);
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_mclk);
    #1;
    o_rd = 1'b0;
    d = i_rdata;
    @(posedge i_mclk);
    #1;
  endtask
endmodule
`default_nettype wire

/* reader_status_registers_test.sv */
// self-checking bench for the reader status register bank
// assumes inputs change 1 ns after each rising edge
`timescale 1ns/10ps
`default_nettype none
module reader_status_registers_test;
  logic clk = 1'b0, rst_n = 1'b0;
  logic busy = 0, fin = 0, rzero = 0, ccmd = 0, cnt = 0, arm = 0, auth = 0;
  logic txr = 0, ss = 0, wopt = 0, rf = 0, done = 0, fast = 0;
  logic [6:0] msrc = 0, men = 0, bc = 0;
  logic [1:0] xsrc = 0, xen = 0, gate = 0;
  logic [5:0] wl = 0, addr;
  logic [7:0] txw = 0, rdat, wdat, d, d2;
  logic wr, rd, filt, tclr, cry, irq, go;
  logic [2:0] ms;
  int fail_count = 0, compares = 0, k, gos;
  // rows: byte count, threshold, expected high/low alerts
  logic [14:0] rows [7] = '{{7'h3C, 6'h04, 2'h2}, {7'h3B, 6'h04, 2'h0},
    {7'h04, 6'h04, 2'h1}, {7'h05, 6'h04, 2'h0}, {7'h40, 6'h00, 2'h2},
    {7'h00, 6'h3F, 2'h1}, {7'h20, 6'h20, 2'h3}};
  always #4 clk = ~clk;
  rdsr_host_model host (.i_mclk(clk), .i_rdata(rdat), .o_addr(addr),
    .o_wr(wr), .o_rd(rd), .o_wdata(wdat));
  rdsr_status_bank uut (.i_mclk(clk), .i_rst_n(rst_n), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdat), .o_reg_rdata(rdat),
    .i_crc_busy(busy), .i_crc_finish(fin), .i_crc_result_zero(rzero),
    .i_checksum_command(ccmd), .i_main_irq_src(msrc),
    .i_main_interrupt_enables(men), .i_misc_irq_src(xsrc),
    .i_misc_interrupt_enables(xen), .i_timer_counting(cnt),
    .i_timer_armed(arm), .i_timer_gate_select(gate),
    .i_buffer_byte_count(bc), .i_watermark_threshold(wl),
    .i_auth_success(auth), .i_tx_request(txr), .i_start_send_request(ss),
    .i_wait_for_field_option(wopt), .i_rf_field_present(rf),
    .i_transmit_wait(txw), .i_tx_done(done), .i_hostbus_fast_mode(fast),
    .o_hostbus_fast_filter(filt), .o_thermal_sensor_clear(tclr),
    .o_encryption_active_flag(cry), .o_irq(irq), .o_tx_go(go),
    .o_modem_state_field(ms));
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // let n edges pass, then 1 ns
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic close_out();
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog well past the roughly 140 cycles of the run
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
  initial begin
    cyc(4);
    rst_n = 1'b1;
    cyc(2);
    host.rd8(6'h07, d);
    chk(d, 8'h21);
    host.rd8(6'h08, d);
    chk(d, 8'h00);
    for (k = 0; k < 7; k++) begin
      bc = rows[k][14:8];
      wl = rows[k][7:2];
      cyc(2);
      host.rd8(6'h07, d);
      chk({6'h00, d[1:0]}, {6'h00, rows[k][1:0]});
    end
    // checksum run: busy drops both flags, finish raises them
    ccmd = 1;
    busy = 1;
    cyc(2);
    host.rd8(6'h07, d);
    chk(d & 8'h60, 8'h00);
    busy = 0;
    fin = 1;
    rzero = 1;
    cyc(1);
    fin = 0;
    cyc(1);
    host.rd8(6'h07, d);
    chk(d & 8'h60, 8'h60);
    // interrupt masking in the main group, then a misc source enabled
    msrc = 7'h01;
    cyc(2);
    chk({7'h00, irq}, 8'h00);
    men = 7'h01;
    cyc(2);
    host.rd8(6'h07, d);
    chk(d & 8'h10, 8'h10);
    men = 7'h00;
    xsrc = 2'h2;
    xen = 2'h2;
    cyc(2);
    chk({7'h00, irq}, 8'h01);
    // timer free-running, then gated with counting low
    cnt = 1;
    cyc(2);
    host.rd8(6'h07, d);
    chk(d & 8'h08, 8'h08);
    cnt = 0;
    gate = 2'h1;
    arm = 1;
    cyc(2);
    host.rd8(6'h07, d);
    chk(d & 8'h08, 8'h08);
    // reads twice, write to read-only register, unmapped read
    host.rd8(6'h07, d);
    host.wr8(6'h07, 8'hFF);
    host.rd8(6'h07, d2);
    chk(d2, d);
    host.rd8(6'h3F, d);
    chk(d, 8'h00);
    host.wr8(6'h08, 8'hFF);
    host.rd8(6'h08, d);
    chk(d, 8'hC0);
    chk({6'h00, tclr, filt}, 8'h03);
    host.wr8(6'h08, 8'h00);
    fast = 1;
    cyc(2);
    chk({7'h00, filt}, 8'h01);
    fast = 0;
    cyc(2);
    chk({7'h00, filt}, 8'h00);
    // authentication sets the flag; only a write clears it
    auth = 1;
    cyc(1);
    auth = 0;
    cyc(8);
    host.rd8(6'h08, d);
    chk(d & 8'h08, 8'h08);
    host.wr8(6'h08, 8'h00);
    cyc(1);
    chk({7'h00, cry}, 8'h00);
    // modem walk with field wait
    txr = 1;
    wopt = 1;
    txw = 8'h02;
    cyc(2);
    chk({5'h00, ms}, 8'h01);
    ss = 1;
    cyc(20);
    host.rd8(6'h08, d);
    chk(d & 8'h07, 8'h02);
    rf = 1;
    gos = 0;
    for (k = 0; k < 10; k++) begin
      gos += go;
      cyc(1);
    end
    chk(gos[7:0], 8'h01);
    chk({5'h00, ms}, 8'h03);
    done = 1;
    cyc(1);
    done = 0;
    txr = 0;
    cyc(1);
    chk({5'h00, ms}, 8'h00);
    // set wins over a same-cycle clear, then a second reset mid-run
    xsrc = 2'h0;
    gate = 2'h0;
    bc = 7'h00;
    auth = 1'b1;
    host.wr8(6'h08, 8'hC0);
    auth = 1'b0;
    chk({6'h00, tclr, cry}, 8'h03);
    rst_n = 1'b0;
    cyc(1);
    chk({4'h0, tclr, cry, filt, irq}, 8'h00);
    chk(rdat, 8'h00);
    rst_n = 1'b1;
    cyc(2);
    host.rd8(6'h07, d);
    chk(d, 8'h21);
    close_out();
  end
endmodule
`default_nettype wire
